/* include/sft_pkg.sv */
// Package with the constants, field layouts and states of the scan fault test sequencer.
package sft_pkg;

  // ****************************************
  // Test record layout
  // ****************************************
  localparam int unsigned NUM_WORDS  = 17;      // Doublewords in one test record.
  localparam int unsigned WORD_CTRL  = 1;       // Word holding mask and test control word.
  localparam int unsigned WORD_ID    = 16;      // Word holding the test numbers.
  localparam logic [3:0]  SCAN_FIRST = 4'hf;    // First word scanned in; scan runs down to 0.

  // Test control word positions, stored with bit 0 of the word in vector bit 31.
  localparam int unsigned CW_LEFT    = 27;      // Left-word select, word bit 4.
  localparam int unsigned CW_UTERM   = 26;      // Unconditional terminate, word bit 5.
  localparam int unsigned CW_CTERM   = 25;      // Conditional terminate, word bit 6.
  localparam int unsigned CW_EXPECT  = 24;      // Expected result flag, word bit 7.
  localparam int unsigned CW_UADDR_L = 12;      // Microcode start address, word bits 8-19.
  localparam int unsigned CW_UADDR_W = 12;
  localparam int unsigned CW_SADDR_L = 6;       // Scan-out word address, word bits 21-25.
  localparam int unsigned CW_SADDR_W = 5;
  localparam int unsigned CW_COUNT_L = 0;       // Clock cycle count, word bits 26-31.
  localparam int unsigned CW_COUNT_W = 6;

  // Word 16: test number high, its complement, search complement, search number low.
  localparam int unsigned ID_TN_L    = 48;
  localparam int unsigned ID_ATN_L   = 0;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0]  OFS_CTRL   = 8'h00;
  localparam logic [7:0]  OFS_STATUS = 8'h04;
  localparam logic [7:0]  OFS_TESTNR = 8'h08;
  localparam logic [7:0]  OFS_CTLWRD = 8'h0c;
  localparam int unsigned CTRL_RUN   = 0;       // Run enable.
  localparam int unsigned CTRL_RESTART = 1;     // Write one: clear indicators, wait for a buffer.
  localparam logic [1:0]  CTRL_RESET = 2'h0;
  localparam logic [31:0] CTLWRD_RESET = 32'h0;

  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_WAIT = 4'h1,
    ST_SCAN = 4'h2,
    ST_ADV  = 4'h3,
    ST_SOUT = 4'h4,
    ST_MASK = 4'h5,
    ST_CMP  = 4'h6,
    ST_DEC  = 4'h7,
    ST_TERM = 4'h8
  } sft_state_e;

endpackage

/* include/sft_core_if.sv */
// Interface joining the sequencer to its compare unit and its cycle counter.
`timescale 1ns/10ps
`default_nettype none
interface sft_core_if #(parameter int unsigned CNT_W = 6);
  logic             resultLoad;
  logic             maskLoad;
  logic [31:0]      wordIn;
  logic             expected;
  logic             match;
  logic             cntLoad;
  logic [CNT_W-1:0] cntValue;
  logic             cntRun;
  logic             cntZero;
  logic             advance;

  modport seq (output resultLoad, maskLoad, wordIn, expected, cntLoad, cntValue, cntRun,
               input match, cntZero, advance);
  modport cmp (input resultLoad, maskLoad, wordIn, expected, output match);
  modport cnt (input cntLoad, cntValue, cntRun, output cntZero, advance);
endinterface
`default_nettype wire

/* hdl/sft_result_compare.sv */
// Result and mask registers with the masked exit-trigger comparison.
`timescale 1ns/10ps
`default_nettype none
module sft_result_compare (
  input wire logic  clk,
  input wire logic  reset_n,
  sft_core_if.cmp   core
);
  logic [31:0] result_r;
  logic [31:0] mask_r;
  wire  [31:0] compareIn;
  wire         exitSet;

  // Result register takes the scanned-out word, mask register the mask half of word 1.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      result_r <= 32'h0;
      mask_r   <= 32'h0;
    end else begin
      if (core.resultLoad) result_r <= core.wordIn;
      if (core.maskLoad) mask_r <= core.wordIn;
    end
  end

  // Mask is ORed onto the scan-out bus and inverted; a set exit trigger gives all zeros.
  assign compareIn  = ~(mask_r | result_r);
  assign exitSet    = ~|compareIn;
  assign core.match = (exitSet == core.expected);
endmodule
`default_nettype wire

/* hdl/sft_cycle_counter.sv */
// Counter of processor clock cycles to advance during a test.
`timescale 1ns/10ps
`default_nettype none
module sft_cycle_counter #(
  parameter int unsigned CNT_W = 6
) (
  input wire logic  clk,
  input wire logic  reset_n,
  sft_core_if.cnt   core
);
  logic [CNT_W-1:0] count_r;

  // Loaded from the control word, then counted down once per advanced cycle.
  always_ff @(posedge clk) begin
    if (!reset_n) count_r <= '0;
    else if (core.cntLoad) count_r <= core.cntValue;
    else if (core.advance) count_r <= count_r - 1'b1;
  end

  // The clock is advanced only while the count is not yet zero.
  assign core.cntZero = (count_r == '0);
  assign core.advance = core.cntRun & ~core.cntZero;
endmodule
`default_nettype wire

/* hdl/sft_scan_sequencer.sv */
// Scan fault test sequencer with test buffers, repeat loop and APB register access.
`timescale 1ns/10ps
`default_nettype none
module sft_scan_sequencer #(
  parameter int unsigned CNT_W = sft_pkg::CW_COUNT_W
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ldWrite,
  input  wire logic        ldBufSel,
  input  wire logic [4:0]  ldWordIdx,
  input  wire logic [63:0] ldData,
  input  wire logic        bufferReadyPulse,
  input  wire logic        gapPulse,
  output logic             scanInValid,
  output logic      [3:0]  scanInIdx,
  output logic      [63:0] scanInData,
  output logic             clockAdvance,
  output logic      [11:0] microcodeStart,
  output logic             scanOutReq,
  output logic      [4:0]  scanOutAddr,
  output logic             leftWordSelect,
  input  wire logic [31:0] scanOutWord,
  output logic             passInd,
  output logic             failInd,
  output logic             terminated,
  output logic      [15:0] displayTestNum
);

  // ****************************************
  // Declarations
  // ****************************************
  sft_core_if #(.CNT_W(CNT_W)) core ();

  sft_pkg::sft_state_e state_r;
  sft_pkg::sft_state_e state_nxt;
  logic [63:0] bufMem [0:2*sft_pkg::NUM_WORDS-1];
  logic        execBuf_r;
  logic [3:0]  scanIdx_r;
  logic [31:0] ctlWord_r;
  logic        pass_r;
  logic        fail_r;
  logic        readyPend_r;
  logic        gapPend_r;
  logic [15:0] testNum_r;
  logic [15:0] searchNum_r;
  logic        run_r;
  logic [31:0] prdata_r;
  logic        pslverr_r;

  // Reads a field of the test control word by position and width.
  function automatic logic [11:0] cwField(input logic [31:0] cw, input int unsigned lo,
                                          input int unsigned w);
    logic [31:0] shifted;
    shifted = (cw >> lo) & ((32'h1 << w) - 32'h1);
    return shifted[11:0];
  endfunction

  // Maps a buffer and a word number to a storage index.
  function automatic logic [5:0] memIdx(input logic buf_sel, input logic [4:0] word);
    return buf_sel ? (6'(word) + 6'(sft_pkg::NUM_WORDS)) : {1'b0, word};
  endfunction

  // ****************************************
  // Test buffers
  // ****************************************

  // The loader writes whole doublewords into either buffer; words above 16 are dropped.
  wire ldInRange = (ldWordIdx < 5'(sft_pkg::NUM_WORDS));

  always_ff @(posedge clk) begin
    if (ldWrite && ldInRange) bufMem[memIdx(ldBufSel, ldWordIdx)] <= ldData;
  end

  // Words the sequencer reads from the buffer under execution.
  wire [63:0] scanWord = bufMem[memIdx(execBuf_r, {1'b0, scanIdx_r})];
  wire [63:0] ctlWord  = bufMem[memIdx(execBuf_r, 5'(sft_pkg::WORD_CTRL))];
  wire [63:0] idWord   = bufMem[memIdx(execBuf_r, 5'(sft_pkg::WORD_ID))];

  // ****************************************
  // Control word decode
  // ****************************************

  // Single flags and fields of the held control word; bits 0-3 and 20 drive nothing.
  wire cwLeft    = ctlWord_r[sft_pkg::CW_LEFT];
  wire cwUterm   = ctlWord_r[sft_pkg::CW_UTERM];
  wire cwCterm   = ctlWord_r[sft_pkg::CW_CTERM];
  wire cwExpect  = ctlWord_r[sft_pkg::CW_EXPECT];
  wire [11:0] cwUaddr = cwField(ctlWord_r, sft_pkg::CW_UADDR_L, sft_pkg::CW_UADDR_W);
  wire [11:0] cwSaddr = cwField(ctlWord_r, sft_pkg::CW_SADDR_L, sft_pkg::CW_SADDR_W);
  wire [11:0] cwCount = cwField(ctlWord_r, sft_pkg::CW_COUNT_L, sft_pkg::CW_COUNT_W);

  // ****************************************
  // Sequence control
  // ****************************************

  // Loop-end events; a pulse in the cycle of the consume keeps its flag set.
  wire loopEnd     = readyPend_r | gapPend_r;
  wire consumeWait = (state_r == sft_pkg::ST_WAIT) && readyPend_r;
  wire consumeDec  = (state_r == sft_pkg::ST_DEC);
  wire terminate   = cwUterm | fail_r | (cwCterm & fail_r);
  wire restartWr;

  // Next state: scan, advance, scan out, mask, compare, repeat or decide.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      sft_pkg::ST_IDLE: begin
        if (run_r) state_nxt = sft_pkg::ST_WAIT;
      end
      sft_pkg::ST_WAIT: begin
        if (readyPend_r) state_nxt = sft_pkg::ST_SCAN;
      end
      sft_pkg::ST_SCAN: begin
        if (scanIdx_r == 4'h0) state_nxt = sft_pkg::ST_ADV;
      end
      sft_pkg::ST_ADV: begin
        if (core.cntZero) state_nxt = sft_pkg::ST_SOUT;
      end
      sft_pkg::ST_SOUT: begin
        state_nxt = sft_pkg::ST_MASK;
      end
      sft_pkg::ST_MASK: begin
        state_nxt = sft_pkg::ST_CMP;
      end
      sft_pkg::ST_CMP: begin
        state_nxt = loopEnd ? sft_pkg::ST_DEC : sft_pkg::ST_SCAN;
      end
      sft_pkg::ST_DEC: begin
        if (terminate) state_nxt = sft_pkg::ST_TERM;
        else if (readyPend_r) state_nxt = sft_pkg::ST_SCAN;
        else state_nxt = sft_pkg::ST_WAIT;
      end
      sft_pkg::ST_TERM: begin
        state_nxt = sft_pkg::ST_TERM;
      end
      default: begin
        state_nxt = sft_pkg::ST_IDLE;
      end
    endcase
    if (!run_r) state_nxt = sft_pkg::ST_IDLE;
    else if (restartWr) state_nxt = sft_pkg::ST_WAIT;
  end

  // State register and scan word index; each test scan starts from word 15.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_r   <= sft_pkg::ST_IDLE;
      scanIdx_r <= sft_pkg::SCAN_FIRST;
    end else begin
      state_r <= state_nxt;
      if (state_r == sft_pkg::ST_SCAN && scanIdx_r != 4'h0) scanIdx_r <= scanIdx_r - 4'h1;
      else scanIdx_r <= sft_pkg::SCAN_FIRST;
    end
  end

  // Pending buffer-ready and gap events; set wins over the consume.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      readyPend_r <= 1'b0;
      gapPend_r   <= 1'b0;
    end else begin
      readyPend_r <= bufferReadyPulse | (readyPend_r & ~(consumeWait | consumeDec));
      gapPend_r   <= gapPulse | (gapPend_r & ~consumeDec);
    end
  end

  // Buffer under execution alternates at each loop end that does not terminate, following the loader.
  always_ff @(posedge clk) begin
    if (!reset_n) execBuf_r <= 1'b0;
    else if (restartWr || !run_r) execBuf_r <= 1'b0;
    else if (consumeDec && !terminate) execBuf_r <= ~execBuf_r;
  end

  // Control word is taken when the scan reaches word 1.
  always_ff @(posedge clk) begin
    if (!reset_n) ctlWord_r <= sft_pkg::CTLWRD_RESET;
    else if (state_r == sft_pkg::ST_SCAN && scanIdx_r == 4'(sft_pkg::WORD_CTRL))
      ctlWord_r <= ctlWord[31:0];
  end

  // Pass and fail collect over runs and clear only when a new test starts or a restart is written.
  wire newTest = consumeWait | (consumeDec & ~terminate & readyPend_r) | restartWr;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pass_r <= 1'b0;
      fail_r <= 1'b0;
    end else if (state_r == sft_pkg::ST_CMP) begin
      pass_r <= pass_r | core.match;
      fail_r <= fail_r | ~core.match;
    end else if (newTest) begin
      pass_r <= 1'b0;
      fail_r <= 1'b0;
    end
  end

  // On termination the test numbers of word 16 are held for display.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      testNum_r   <= 16'h0;
      searchNum_r <= 16'h0;
    end else if (consumeDec && terminate) begin
      testNum_r   <= idWord[sft_pkg::ID_TN_L +: 16];
      searchNum_r <= idWord[sft_pkg::ID_ATN_L +: 16];
    end
  end

  // ****************************************
  // Compare unit and cycle counter
  // ****************************************

  // Scan-out word goes to the result register, mask half of word 1 to the mask register.
  assign core.resultLoad = (state_r == sft_pkg::ST_SOUT);
  assign core.maskLoad   = (state_r == sft_pkg::ST_MASK);
  assign core.wordIn     = core.maskLoad ? ctlWord[63:32] : scanOutWord;
  assign core.expected   = cwExpect;
  assign core.cntLoad    = (state_r == sft_pkg::ST_SCAN) && (scanIdx_r == 4'h0);
  assign core.cntValue   = cwCount[CNT_W-1:0];
  assign core.cntRun     = (state_r == sft_pkg::ST_ADV);

  sft_result_compare u_compare (
    .clk     (clk),
    .reset_n (reset_n),
    .core    (core)
  );

  sft_cycle_counter #(.CNT_W(CNT_W)) u_counter (
    .clk     (clk),
    .reset_n (reset_n),
    .core    (core)
  );

  // ****************************************
  // Processor side outputs
  // ****************************************

  // Words 0 and 2 to 15 go out to the triggers; word 1 stays inside the sequencer.
  assign scanInValid    = (state_r == sft_pkg::ST_SCAN) &&
                          (scanIdx_r != 4'(sft_pkg::WORD_CTRL));
  assign scanInIdx      = scanIdx_r;
  assign scanInData     = scanWord;
  assign clockAdvance   = core.advance;
  assign microcodeStart = cwUaddr;
  assign scanOutReq     = (state_r == sft_pkg::ST_SOUT);
  assign scanOutAddr    = cwSaddr[4:0];
  assign leftWordSelect = cwLeft;
  assign passInd        = pass_r;
  assign failInd        = fail_r;
  assign terminated     = (state_r == sft_pkg::ST_TERM);
  assign displayTestNum = testNum_r;

  // ****************************************
  // APB register access
  // ****************************************

  // Address decode for the setup and access phases.
  wire setupPh  = psel & ~penable;
  wire accessPh = psel & penable;
  wire hitCtrl  = (paddr == sft_pkg::OFS_CTRL);
  wire hitStat  = (paddr == sft_pkg::OFS_STATUS);
  wire hitTnr   = (paddr == sft_pkg::OFS_TESTNR);
  wire hitCwd   = (paddr == sft_pkg::OFS_CTLWRD);
  wire mapped   = hitCtrl | hitStat | hitTnr | hitCwd;
  assign restartWr = accessPh & pwrite & hitCtrl & pwdata[sft_pkg::CTRL_RESTART];

  // Read data selection from the block's own state.
  wire [31:0] statusWord = {20'h0, state_r, 3'h0, execBuf_r, run_r, terminated, fail_r, pass_r};
  wire [31:0] readMux    = hitCtrl ? {31'h0, run_r} :
                           hitStat ? statusWord :
                           hitTnr  ? {searchNum_r, testNum_r} :
                           hitCwd  ? ctlWord_r : 32'h0;

  // Run enable is written in the access phase.
  always_ff @(posedge clk) begin
    if (!reset_n) run_r <= sft_pkg::CTRL_RESET[sft_pkg::CTRL_RUN];
    else if (accessPh && pwrite && hitCtrl) run_r <= pwdata[sft_pkg::CTRL_RUN];
  end

  // Read data and error answer are prepared in the setup phase.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prdata_r  <= 32'h0;
      pslverr_r <= 1'b0;
    end else if (setupPh) begin
      prdata_r  <= pwrite ? 32'h0 : readMux;
      pslverr_r <= ~mapped;
    end
  end

  assign prdata  = prdata_r;
  assign pslverr = pslverr_r & accessPh;
  assign pready  = 1'b1;

endmodule
`default_nettype wire

/* tb/sft_assertions.sv */
// Checker of the scan fault test sequencer port behaviour.
`timescale 1ns/10ps
`default_nettype none
module sft_assertions #(
  parameter int unsigned CNT_W = 6
) (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        scanInValid,
  input wire logic [3:0]  scanInIdx,
  input wire logic        clockAdvance,
  input wire logic        scanOutReq,
  input wire logic        passInd,
  input wire logic        failInd,
  input wire logic        terminated
);
  // Every check runs on the core clock and sleeps in reset.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Register bus answers at once and flags holes in the map.
  a_no_wait:
    assert property (pready) else $error("wait state inserted");
  a_slverr_map:
    assert property (psel && penable |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c}))
      else $error("error response does not follow the map");
  a_write_rdzero:
    assert property (psel && penable && pwrite |-> prdata == 32'h0) else $error("read data on a write");
  // Scan-in walks down the words and leaves out the control word.
  a_scan_down:
    assert property (scanInValid && scanInIdx > 4'h2 |=> scanInValid && scanInIdx == $past(scanInIdx) - 4'h1)
      else $error("scan order broken");
  a_skip_ctl:
    assert property (scanInValid && scanInIdx == 4'h2 |=> !scanInValid ##1 scanInValid && scanInIdx == 4'h0)
      else $error("control word scanned or word 0 missed");
  // Clock advance ends straight into one scan-out.
  a_adv_alone:
    assert property (clockAdvance |-> !scanInValid && !scanOutReq) else $error("advance overlaps scan");
  a_adv_then_out:
    assert property ($fell(clockAdvance) |=> scanOutReq) else $error("no scan-out after advance");
  a_req_single:
    assert property (scanOutReq |=> !scanOutReq [*8]) else $error("scan-out repeated too soon");
  // Indicators rise only after scan-out, mask and compare cycles.
  a_pass_cause:
    assert property ($rose(passInd) |-> $past(scanOutReq, 3)) else $error("pass set off the compare cycle");
  a_fail_cause:
    assert property ($rose(failInd) |-> $past(scanOutReq, 3)) else $error("fail set off the compare cycle");
  // A terminated sequencer stays quiet until software writes.
  a_term_quiet:
    assert property (terminated |-> !scanInValid && !clockAdvance && !scanOutReq) else $error("activity after stop");
  a_term_keep:
    assert property (terminated && !(psel && pwrite) |=> terminated) else $error("stop released on its own");
endmodule
bind sft_scan_sequencer sft_assertions #(.CNT_W(CNT_W)) u_chk (.clk, .reset_n, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .scanInValid, .scanInIdx, .clockAdvance, .scanOutReq, .passInd,
  .failInd, .terminated);
`default_nettype wire

/* tb/sft_loader_model.sv */
// Behavioural loader that fills the two test buffers and flags each full one.
`timescale 1ns/10ps
`default_nettype none
module sft_loader_model (
  input  wire logic        clk,
  output logic             ldWrite,
  output logic             ldBufSel,
  output logic      [4:0]  ldWordIdx,
  output logic      [63:0] ldData,
  output logic             bufferReadyPulse,
  output logic             gapPulse
);
  localparam int unsigned RECORD_BYTES = 32'h88;
  localparam int unsigned BOOT_BYTES   = 32'h18;

  logic [63:0] image [sft_pkg::NUM_WORDS];

  // The loader starts quiet.
  initial begin
    ldWrite = 1'b0;
    ldBufSel = 1'b0;
    ldWordIdx = 5'h0;
    ldData = 64'h0;
    bufferReadyPulse = 1'b0;
    gapPulse = 1'b0;
  end

  // Writes one whole test word by word, then flags the buffer as ready.
  task automatic fill(input logic sel);
    for (int i = 0; i < RECORD_BYTES / 8; i++) begin
      @(posedge clk);
      ldWrite <= 1'b1;
      ldBufSel <= sel;
      ldWordIdx <= 5'(i);
      ldData <= image[i];
      @(posedge clk);
      ldWrite <= 1'b0;
      ldData <= ~image[i];
    end
    @(posedge clk);
    bufferReadyPulse <= 1'b1;
    @(posedge clk);
    bufferReadyPulse <= 1'b0;
  endtask

  // Bootstrap records of three doublewords land outside the test buffers, so the strobe stays low.
  task automatic boot();
    repeat (BOOT_BYTES / 8) @(posedge clk);
  endtask

  // Signals the gap that ends a tape record.
  task automatic gap();
    @(posedge clk);
    gapPulse <= 1'b1;
    @(posedge clk);
    gapPulse <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* tb/scan_fault_test_sequencer_test.sv */
// Self-checking bench for the scan fault test sequencer.
`timescale 1ns/10ps
`default_nettype none
module scan_fault_test_sequencer_test;
  logic        clk, reset_n, psel, penable, pwrite, pready, pslverr, err, alt, ep, ef;
  logic        ldWrite, ldBufSel, bufferReadyPulse, gapPulse, scanInValid, clockAdvance;
  logic        scanOutReq, leftWordSelect, passInd, failInd, terminated;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, scanOutWord, rd, cwNow;
  logic [4:0]  ldWordIdx, scanOutAddr;
  logic [63:0] ldData, scanInData;
  logic [3:0]  scanInIdx;
  logic [1:0]  curK;
  logic [11:0] microcodeStart;
  logic [15:0] displayTestNum;
  logic [31:0] tMask [4], tCw [4];
  logic [63:0] tW0 [4], tW16 [4];
  logic [1:0]  tMode [4];
  int          errorCnt, numChecks, advCnt, lastK;

  sft_scan_sequencer dut (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .ldWrite, .ldBufSel, .ldWordIdx, .ldData, .bufferReadyPulse, .gapPulse, .scanInValid,
    .scanInIdx, .scanInData, .clockAdvance, .microcodeStart, .scanOutReq, .scanOutAddr, .leftWordSelect,
    .scanOutWord, .passInd, .failInd, .terminated, .displayTestNum);
  sft_loader_model ldr (.clk, .ldWrite, .ldBufSel, .ldWordIdx, .ldData, .bufferReadyPulse, .gapPulse);

  // The running test is known from its microcode start address.
  assign curK = microcodeStart[1:0];
  assign cwNow = tCw[curK];

  // Free-running core clock.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    numChecks++;
    if (seen !== exp) begin
      errorCnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic finalReport();
    $display("checks %0d mismatches %0d", numChecks, errorCnt);
    if (errorCnt == 0 && numChecks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic tmo();
    errorCnt++;
    $display("unexpected timeout");
    finalReport();
  endtask

  // One register transfer; the reply is taken at the edge that sees pready.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) tmo();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Waits for n scan-out requests, or for a stop when n is zero.
  task automatic waitEv(input int n);
    int c, t;
    c = 0;
    t = 0;
    while (n == 0 ? terminated !== 1'b1 : c < n) begin
      @(posedge clk);
      t++;
      if (scanOutReq === 1'b1) c++;
      if (t > 9000) tmo();
    end
    #1;
  endtask

  // Builds test k in the loader image and in the reference tables.
  task automatic mkTest(input int k, input logic [1:0] mode, input logic [3:0] flags, input logic [5:0] cnt,
                        input logic zero);
    logic [31:0] cw;
    logic [15:0] tn, sn;
    cw = $urandom;
    cw[sft_pkg::CW_EXPECT +: 4] = flags;
    cw[sft_pkg::CW_UADDR_L +: 12] = {10'h2a5, 2'(k)};
    cw[sft_pkg::CW_SADDR_L +: 5] = 5'($urandom);
    cw[sft_pkg::CW_COUNT_L +: 6] = cnt;
    tn = 16'($urandom);
    sn = 16'($urandom);
    tMask[k] = ~(32'h1 << ($urandom % 32));
    tCw[k] = cw;
    tMode[k] = mode;
    tW16[k] = {tn, ~tn, ~sn, sn};
    for (int i = 0; i < 17; i++) ldr.image[i] = zero ? 64'h0 : {$urandom, $urandom};
    ldr.image[1] = {tMask[k], cw};
    ldr.image[16] = tW16[k];
    tW0[k] = ldr.image[0];
  endtask

  // Processor side: the scanned word hits or misses the exit trigger as the test asks.
  always @(posedge clk) begin
    if (scanOutReq === 1'b1) alt <= ~alt;
    if (tMode[curK] == 2'h0 || (tMode[curK] == 2'h2 && alt)) scanOutWord <= $urandom | ~tMask[curK];
    else scanOutWord <= $urandom & tMask[curK];
  end

  // Reference model of scan-in, advance and compare, checked at every result.
  always begin
    @(posedge clk);
    if (reset_n === 1'b1 && scanInValid === 1'b1 && scanInIdx === 4'h0) check("word0", scanInData, tW0[curK]);
    if (reset_n === 1'b1 && scanOutReq === 1'b1) begin
      check("cycles", 64'(advCnt), 64'(cwNow[sft_pkg::CW_COUNT_L +: 6]));
      check("fields", {leftWordSelect, scanOutAddr, microcodeStart}, {cwNow[sft_pkg::CW_LEFT],
            cwNow[sft_pkg::CW_SADDR_L +: 5], cwNow[sft_pkg::CW_UADDR_L +: 12]});
      if (curK != lastK) begin
        ep = 1'b0;
        ef = 1'b0;
        lastK = curK;
      end
      if (((tMask[curK] | scanOutWord) == 32'hffffffff) == cwNow[sft_pkg::CW_EXPECT]) ep = 1'b1;
      else ef = 1'b1;
      advCnt = 0;
      repeat (2) @(posedge clk);
      #1;
      check("pass", passInd, ep);
      check("fail", failInd, ef);
    end else if (clockAdvance === 1'b1) advCnt++;
  end

  // Main sequence.
  initial begin
    {reset_n, psel, penable, pwrite, alt, ep, ef} = 7'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    scanOutWord = 32'h0;
    errorCnt = 0;
    numChecks = 0;
    advCnt = 0;
    lastK = -1;
    void'($urandom(32'h8d75));
    mkTest(0, 2'h0, 4'b1001, 6'h3f, 1'b0);
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    for (int a = 0; a < 20; a += 4) begin
      apb(1'b0, 8'(a), 32'h0);
      check("rdata", rd, 64'h0);
      check("slverr", err, 64'(a == 16));
    end
    apb(1'b1, 8'h10, 32'hffffffff);
    check("slverr", err, 64'h1);
    apb(1'b1, sft_pkg::OFS_CTRL, 32'h1);
    apb(1'b0, sft_pkg::OFS_CTRL, 32'h0);
    check("ctrl", rd, 64'h1);
    $display("done: registers");
    ldr.boot();
    ldr.fill(1'b0);
    waitEv(2);
    mkTest(1, 2'h2, 4'b0000, 6'(1 + $urandom % 5), 1'b0);
    ldr.fill(1'b1);
    waitEv(6);
    mkTest(2, 2'h0, 4'b0001, 6'h1, 1'b0);
    ldr.fill(1'b0);
    waitEv(0);
    check("testnum", displayTestNum, tW16[1][63:48]);
    check("intermittent", {passInd, failInd}, 64'h3);
    apb(1'b0, sft_pkg::OFS_TESTNR, 32'h0);
    check("testnr", rd, {tW16[1][15:0], tW16[1][63:48]});
    apb(1'b0, sft_pkg::OFS_CTLWRD, 32'h0);
    check("ctlwrd", rd, tCw[1]);
    apb(1'b0, sft_pkg::OFS_STATUS, 32'h0);
    check("status", {rd[11:8], rd[3:0]}, 64'h8f);
    $display("done: intermittent stop");
    apb(1'b1, sft_pkg::OFS_CTRL, 32'h3);
    mkTest(3, 2'h1, 4'b0100, 6'h0, 1'b1);
    ldr.fill(1'b0);
    waitEv(2);
    ldr.gap();
    waitEv(0);
    check("testnum", displayTestNum, tW16[3][63:48]);
    check("passonly", {passInd, failInd}, 64'h2);
    $display("done: stop on gap");
    finalReport();
  end
endmodule
`default_nettype wire
